// *** tos_defines.svh ***
// Constants for the timing output selector
`ifndef TOS_DEFINES_SVH
`define TOS_DEFINES_SVH
`define TOS_NUM_OUTPUTS       3
`define TOS_SEL_W             4
`define TOS_STD_W             6
`define TOS_STD_OFF           6'h00
`define TOS_SRC_H_SYNC        4'h0
`define TOS_SRC_H_BLANK       4'h1
`define TOS_SRC_V_SYNC        4'h2
`define TOS_SRC_V_BLANK       4'h3
`define TOS_SRC_F_SYNC        4'h4
`define TOS_SRC_F_DIGITAL     4'h5
`define TOS_SRC_DISP_EN       4'h6
`define TOS_SRC_CADENCE_ID    4'h7
`define TOS_SRC_AV_FRAME      4'h8
`define TOS_SRC_USER_1        4'h9
`define TOS_SRC_USER_2        4'ha
`define TOS_SRC_USER_3        4'hb
`define TOS_SRC_USER_4        4'hc
`define TOS_NUM_SOURCES       13
`define TOS_RST_SEL_0         4'h5
`define TOS_RST_SEL_1         4'h7
`define TOS_RST_SEL_2         4'h6
`define TOS_RST_DRIVE         1'b0
`define TOS_SYNC_FILL         2'h2
`endif

// *** tos_pkg.sv ***
// Types for the timing output selector
`include "tos_defines.svh"
package tos_pkg;
  typedef logic [`TOS_SEL_W-1:0]       tos_sel_t;
  typedef logic [`TOS_STD_W-1:0]       tos_std_t;
  typedef logic [`TOS_NUM_SOURCES-1:0] tos_src_vec_t;
endpackage

// *** tos_out_lane.sv ***
// One timing output lane: source select, drive strength and tristate control
`timescale 1ns/1ps
`include "tos_defines.svh"
module tos_out_lane #(
  parameter logic [`TOS_SEL_W-1:0] RST_SEL = `TOS_RST_SEL_0
) (
  input  wire logic              clock_i,
  input  wire logic              sys_rst_i,
  input  wire tos_pkg::tos_src_vec_t src_i,
  input  wire logic              sel_we_i,
  input  wire tos_pkg::tos_sel_t sel_i,
  input  wire logic              drv_we_i,
  input  wire logic              drv_i,
  input  wire logic              std_off_i,
  output logic                   pin_o,
  output logic                   pin_oe_o,
  output logic                   drive_high_o,
  output tos_pkg::tos_sel_t      sel_o
);
  import tos_pkg::*;

  tos_sel_t sel_r;
  logic     drv_r;
  logic     picked;

  // Selection held until the host rewrites it
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sel_r <= RST_SEL;
    end else if (sel_we_i) begin
      sel_r <= sel_i;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      drv_r <= `TOS_RST_DRIVE;
    end else if (drv_we_i) begin
      drv_r <= drv_i;
    end
  end

  // Codes beyond the last source read as low rather than wrapping
  always_comb begin
    picked = 1'b0;
    if (sel_r < `TOS_SEL_W'(`TOS_NUM_SOURCES)) begin
      picked = src_i[sel_r];
    end
  end

  // Registered so the pin moves only on pixel clock edges
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_o    <= 1'b0;
      pin_oe_o <= 1'b0;
    end else begin
      pin_o    <= picked;
      pin_oe_o <= ~std_off_i;
    end
  end

  assign drive_high_o = drv_r;
  assign sel_o        = sel_r;
endmodule

// *** tos_timing_out_select.sv ***
// Top of the timing output selector: three selectable timing pins
`timescale 1ns/1ps
`include "tos_defines.svh"
module tos_timing_out_select #(
  parameter int NUM_OUT = `TOS_NUM_OUTPUTS
) (
  input  wire logic                  clock_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  h_sync_i,
  input  wire logic                  h_blank_i,
  input  wire logic                  v_sync_i,
  input  wire logic                  v_blank_i,
  input  wire logic                  f_sync_i,
  input  wire logic                  f_digital_i,
  input  wire logic                  display_enable_signal_i,
  input  wire logic                  ten_field_cadence_id_i,
  input  wire logic                  audio_video_frame_timing_i,
  input  wire logic [3:0]            user_timing_i,
  input  wire tos_pkg::tos_std_t     video_standard_select_i,
  input  wire logic [NUM_OUT-1:0]    sel_we_i,
  input  wire tos_pkg::tos_sel_t     sel_i,
  input  wire logic [NUM_OUT-1:0]    drv_we_i,
  input  wire logic                  drv_i,
  output logic [NUM_OUT-1:0]         timing_out_o,
  output logic [NUM_OUT-1:0]         timing_oe_o,
  output logic [NUM_OUT-1:0]         drive_high_o,
  output tos_pkg::tos_std_t          default_format_o,
  output logic                       std_off_o
);
  import tos_pkg::*;

  localparam logic [`TOS_SEL_W-1:0] RST_SEL [3] = '{`TOS_RST_SEL_0, `TOS_RST_SEL_1, `TOS_RST_SEL_2};

  tos_std_t     std_meta_r;
  tos_std_t     std_sync_r;
  tos_std_t     fmt_r;
  logic         fmt_taken_r;
  logic [1:0]   fill_r;
  logic         off_r;
  tos_src_vec_t src_meta_r;
  tos_src_vec_t src_sync_r;
  tos_src_vec_t src_raw;
  tos_sel_t     sel_mon [NUM_OUT];

  assign src_raw = {user_timing_i, audio_video_frame_timing_i, ten_field_cadence_id_i,
                    display_enable_signal_i, f_digital_i, f_sync_i, v_blank_i,
                    v_sync_i, h_blank_i, h_sync_i};

  // Pin inputs pass two flops before use
  // Strap pins are static; a change in flight can show one mixed code for a cycle
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      std_meta_r <= `TOS_STD_OFF;
      std_sync_r <= `TOS_STD_OFF;
    end else begin
      std_meta_r <= video_standard_select_i;
      std_sync_r <= std_meta_r;
    end
  end

  // Timing sources come from another clock region in general, so resync them too
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      src_meta_r <= '0;
      src_sync_r <= '0;
    end else begin
      src_meta_r <= src_raw;
      src_sync_r <= src_meta_r;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      off_r <= 1'b1;
    end else begin
      off_r <= (std_sync_r == `TOS_STD_OFF);
    end
  end

  // Sync chains are held in reset, so wait until they carry real pin values
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fill_r <= 2'h0;
    end else if (fill_r != `TOS_SYNC_FILL) begin
      fill_r <= fill_r + 2'h1;
    end
  end

  // Default format taken once, after the chain has filled
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fmt_r       <= `TOS_STD_OFF;
      fmt_taken_r <= 1'b0;
    end else if (!fmt_taken_r && (fill_r == `TOS_SYNC_FILL)) begin
      fmt_r       <= std_sync_r;
      fmt_taken_r <= 1'b1;
    end
  end

  assign default_format_o = fmt_r;
  assign std_off_o        = off_r;

  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++) begin : g_lane
      tos_out_lane #(
        .RST_SEL (RST_SEL[g])
      ) u_lane (
        .clock_i      (clock_i),
        .sys_rst_i    (sys_rst_i),
        .src_i        (src_sync_r),
        .sel_we_i     (sel_we_i[g]),
        .sel_i        (sel_i),
        .drv_we_i     (drv_we_i[g]),
        .drv_i        (drv_i),
        .std_off_i    (off_r),
        .pin_o        (timing_out_o[g]),
        .pin_oe_o     (timing_oe_o[g]),
        .drive_high_o (drive_high_o[g]),
        .sel_o        (sel_mon[g])
      );

      // Spare codes must read low, not alias a real source
      sel_src_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (sel_mon[g] < `TOS_SEL_W'(`TOS_NUM_SOURCES)) |=> timing_out_o[g] == $past(src_sync_r[sel_mon[g]]))
        else $error("timing output does not follow selected source");
      drv_hold_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        !drv_we_i[g] |=> $stable(drive_high_o[g]))
        else $error("drive strength changed without write");
      drv_load_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        drv_we_i[g] |=> drive_high_o[g] == $past(drv_i))
        else $error("drive strength write lost");
      sel_hold_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        !sel_we_i[g] |=> $stable(sel_mon[g]))
        else $error("selection changed without write");
      sel_load_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        sel_we_i[g] |=> sel_mon[g] == $past(sel_i))
        else $error("selection write lost");
      sel_spare_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (sel_mon[g] >= `TOS_SEL_W'(`TOS_NUM_SOURCES)) |=> !timing_out_o[g])
        else $error("unused source code does not read low");
    end
  endgenerate

  sequence s_std_zero;
    std_sync_r == `TOS_STD_OFF;
  endsequence
  sequence s_std_nonzero;
    std_sync_r != `TOS_STD_OFF;
  endsequence
  sequence s_chain_full;
    fill_r == `TOS_SYNC_FILL;
  endsequence
  sequence s_fmt_due;
    !fmt_taken_r && (fill_r == `TOS_SYNC_FILL);
  endsequence
  sequence s_pin_off;
    video_standard_select_i == `TOS_STD_OFF;
  endsequence
  sequence s_pin_on;
    video_standard_select_i != `TOS_STD_OFF;
  endsequence

  std_off_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    s_std_zero |=> ##1 (timing_oe_o == '0))
    else $error("outputs driven while standard select is zero");
  std_on_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    s_std_nonzero ##1 s_std_nonzero |=> ##1 (timing_oe_o == '1))
    else $error("outputs not driven for nonzero standard");
  fmt_hold_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    fmt_taken_r |=> $stable(default_format_o))
    else $error("default format changed after capture");
  rst_sel_a: assert property (@(posedge clock_i)
    $fell(sys_rst_i) |-> (sel_mon[0] == `TOS_RST_SEL_0) && (sel_mon[NUM_OUT-1] == `TOS_RST_SEL_2))
    else $error("reset selection wrong");
  rst_cad_a: assert property (@(posedge clock_i)
    $fell(sys_rst_i) |-> sel_mon[1] == `TOS_RST_SEL_1)
    else $error("second output reset selection wrong");
  rst_drv_a: assert property (@(posedge clock_i)
    $fell(sys_rst_i) |-> (drive_high_o == '0) && (sel_mon[2] == `TOS_SRC_DISP_EN))
    else $error("reset drive or display enable selection wrong");

  // Format must come from the pins, never from the reset value of the chain
  fmt_load_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    s_fmt_due |=> fmt_taken_r && (default_format_o == $past(std_sync_r)))
    else $error("default format not taken from standard select");
  fmt_idle_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !fmt_taken_r |-> default_format_o == `TOS_STD_OFF)
    else $error("default format shown before capture");
  std_chain_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    s_chain_full |-> std_sync_r == $past(video_standard_select_i, 2))
    else $error("standard select chain depth wrong");
  src_chain_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    s_chain_full |-> src_sync_r == $past(src_raw, 2))
    else $error("timing source chain depth wrong");

  // End to end: a pin level reaches the enables four edges later
  pin_zero_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    s_pin_off |-> ##4 (timing_oe_o == '0))
    else $error("zero standard not reflected on enables");
  pin_live_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    s_pin_on |-> ##4 (timing_oe_o == '1))
    else $error("nonzero standard not reflected on enables");
  oe_same_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (timing_oe_o == '0) || (timing_oe_o == '1))
    else $error("timing enables disagree between lanes");
  oe_off_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    std_off_o |=> timing_oe_o == '0)
    else $error("outputs driven while flagged off");
  oe_on_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !std_off_o |=> timing_oe_o == '1)
    else $error("outputs released while flagged on");
endmodule

// *** tos_sink_model.sv ***
// Downstream sink model that sees the timing pins as the board does
`timescale 1ns/1ps
module tos_sink_model #(
  parameter int N = 3
) (
  input  wire logic         clock_i,
  input  wire logic [N-1:0] pin_i,
  input  wire logic [N-1:0] oe_i,
  output logic      [N-1:0] level_o
);
  logic [N-1:0] last_r;
  always_ff @(posedge clock_i) begin
    for (int i = 0; i < N; i++) begin
      if (oe_i[i]) last_r[i] <= pin_i[i];
    end
  end
  // A released pin shows the inverse of its last value, so a stale copy never passes
  always_comb begin
    for (int i = 0; i < N; i++) begin
      level_o[i] = oe_i[i] ? pin_i[i] : ~last_r[i];
    end
  end
endmodule

// *** timing_output_select_tb.sv ***
// Self-checking bench for the timing output selector
`timescale 1ns/1ps
module timing_output_select_tb;
  import tos_pkg::*;
  logic       clock_i = 0;
  logic       sys_rst_i = 1;
  logic [12:0] src = '0;
  tos_std_t   std = 6'h05;
  logic [2:0] sel_we = '0;
  logic [2:0] drv_we = '0;
  tos_sel_t   sel = '0;
  logic       drv = 0;
  logic [2:0] out, oe, drv_hi, lvl;
  tos_std_t   fmt;
  logic       off;
  int         fail_count = 0;
  int         n_tests = 0;

  tos_timing_out_select uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .h_sync_i(src[0]), .h_blank_i(src[1]),
    .v_sync_i(src[2]), .v_blank_i(src[3]), .f_sync_i(src[4]), .f_digital_i(src[5]),
    .display_enable_signal_i(src[6]), .ten_field_cadence_id_i(src[7]), .audio_video_frame_timing_i(src[8]),
    .user_timing_i(src[12:9]), .video_standard_select_i(std), .sel_we_i(sel_we), .sel_i(sel),
    .drv_we_i(drv_we), .drv_i(drv), .timing_out_o(out), .timing_oe_o(oe), .drive_high_o(drv_hi),
    .default_format_o(fmt), .std_off_o(off));
  tos_sink_model sink (.clock_i(clock_i), .pin_i(out), .oe_i(oe), .level_o(lvl));

  initial begin
    forever #20 clock_i = ~clock_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic chk(input string nm, input logic [5:0] e, input logic [5:0] g);
    n_tests++;
    if (e !== g) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic t_defaults;
    src = 13'h0060;
    tick(4);
    chk("reset_sel", 6'h05, {3'b0, lvl});
    src = 13'h0080;
    tick(4);
    chk("reset_sel_b", 6'h02, {3'b0, lvl});
    chk("reset_drive", 6'h00, {3'b0, drv_hi});
    chk("format", 6'h05, fmt);
  endtask

  task automatic t_select;
    for (int c = 0; c < 13; c++) begin
      src = 13'h1 << c;
      sel = c[3:0];
      sel_we = 3'b111;
      tick(1);
      sel_we = 3'b000;
      tick(4);
      chk("select", 6'h07, {3'b0, lvl});
    end
    sel = 4'h0;
    sel_we = 3'b010;
    tick(1);
    sel_we = 3'b000;
    tick(4);
    chk("lane_sel", 6'h05, {3'b0, lvl});
    src = 13'h1fff;
    sel = 4'hd;
    sel_we = 3'b111;
    tick(1);
    sel_we = 3'b000;
    tick(4);
    chk("unused_code", 6'h00, {3'b0, lvl});
  endtask

  task automatic t_drive;
    for (int k = 0; k < 2; k++) begin
      drv = 1;
      drv_we = k ? 3'b111 : 3'b010;
      tick(1);
      chk("drive_hi", {3'b0, drv_we}, {3'b0, drv_hi});
      drv = 0;
      tick(1);
      chk("drive_lo", 6'h00, {3'b0, drv_hi});
      drv_we = 3'b000;
      tick(1);
    end
  endtask

  task automatic t_off;
    std = 6'h00;
    tick(6);
    chk("tristate", 6'h00, {3'b0, oe});
    chk("std_off", 6'h01, {5'b0, off});
    chk("format_hold", 6'h05, fmt);
    std = 6'h05;
    tick(6);
    chk("driven", 6'h07, {3'b0, oe});
    chk("std_on", 6'h00, {5'b0, off});
  endtask

  // Mid-run reset must restore default selections and drive strength
  task automatic t_rerun;
    drv = 1;
    drv_we = 3'b111;
    tick(1);
    chk("pre_rst_drive", 6'h07, {3'b0, drv_hi});
    drv_we = 3'b000;
    sys_rst_i = 1;
    tick(2);
    chk("rst_drive", 6'h00, {3'b0, drv_hi});
    sys_rst_i = 0;
    drv = 0;
    t_defaults();
  endtask

  // Source reaches the pin after two sync stages and the output flop
  task automatic t_sync;
    sel = 4'h0;
    sel_we = 3'b111;
    src = 13'h0;
    tick(1);
    sel_we = 3'b000;
    tick(5);
    src = 13'h1;
    tick(1);
    chk("early", 6'h00, {3'b0, lvl});
    tick(2);
    chk("late", 6'h07, {3'b0, lvl});
  endtask

  task automatic report_and_stop;
    if (fail_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    tick(4);
    sys_rst_i = 0;
    t_defaults();
    t_select();
    t_drive();
    t_off();
    t_sync();
    t_rerun();
    report_and_stop();
  end
endmodule
